// ---- core/direct_move_regs.sv ----
// Identifier-addressed direct move parameters, input commands and status words
`default_nettype none
`include "move_cfg.svh"
module direct_move_regs
  import move_pkg::*;
#(
  parameter int AUTO_OFF_CYCLES = `AUTO_OFF_CYC
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Identifier access port
  input  wire logic          acc_req,
  input  wire logic          acc_wr,
  input  wire logic [15:0]   acc_id,
  input  wire logic [31:0]   acc_wdata,
  output logic               acc_ack,
  output logic               acc_err,
  output logic      [31:0]   acc_rdata,
  // Drive state from the motion core
  input  wire drive_status_t drive_status,
  input  wire logic          move_busy,
  input  wire logic          comm_err_valid,
  input  wire logic [31:0]   comm_err_code,
  // Move launch toward the motion core
  output move_params_t       move_params,
  output logic               move_start,
  output logic               move_to_buffer,
  // Driver input signals
  output logic      [31:0]   drv_input
);

  function automatic logic in_range(input logic [31:0] v,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
  endfunction : in_range

  move_params_t params_q;
  move_params_t params_d;
  logic [31:0]  trig_q;
  logic [31:0]  dest_q;
  logic [6:0]   upd_q;
  logic [6:0]   upd_d;
  logic [31:0]  drv_in_q;
  logic [31:0]  drv_in_d;
  logic [31:0]  comm_err_q;
  logic         start_q;
  logic         to_buf_q;
  logic         ack_q;
  logic         err_q;
  logic [31:0]  rdata_q;
  logic [31:0]  clr_mask;

  // Address decode
  wire rd = acc_req & ~acc_wr;
  wire wr = acc_req & acc_wr;
  wire hit_num    = acc_id == `ID_DATA_NUM;
  wire hit_type   = acc_id == `ID_OP_TYPE;
  wire hit_pos    = acc_id == `ID_POSITION;
  wire hit_speed  = acc_id == `ID_SPEED;
  wire hit_rate   = acc_id == `ID_START_RATE;
  wire hit_stop   = acc_id == `ID_STOP_DECEL;
  wire hit_cur    = acc_id == `ID_CURRENT;
  wire hit_trig   = acc_id == `ID_TRIGGER;
  wire hit_dest   = acc_id == `ID_DEST;
  wire hit_mirror = acc_id == `ID_IN_MIRROR;
  wire hit_selfcl = acc_id == `ID_IN_SELFCLR;
  wire hit_main   = acc_id == `ID_IN_MAIN;
  wire hit_outst  = acc_id == `ID_OUT_STATUS;
  wire hit_alarm  = acc_id == `ID_ALARM;
  wire hit_cerr   = acc_id == `ID_COMM_ERR;
  wire hit_cpos   = acc_id == `ID_CMD_POS;
  wire hit_rpm    = acc_id == `ID_CMD_RPM;
  wire hit_hz     = acc_id == `ID_CMD_HZ;

  wire [6:0] item_hit = {hit_cur, hit_stop, hit_rate, hit_speed,
                         hit_pos, hit_type, hit_num};
  wire hit_rw = (|item_hit) | hit_trig | hit_dest;
  wire hit_wo = hit_mirror | hit_selfcl | hit_main;
  wire hit_ro = hit_outst | hit_alarm | hit_cerr | hit_cpos | hit_rpm | hit_hz;

  // Range checks on the written value
  wire ok_num   = in_range(acc_wdata, `ZERO_WORD, `DATA_NUM_MAX);
  wire ok_type  = in_range(acc_wdata, `ZERO_WORD, `OP_TYPE_MAX);
  wire ok_pos   = in_range(acc_wdata, `POS_MIN, `POS_MAX);
  wire ok_speed = in_range(acc_wdata, `SPEED_MIN, `SPEED_MAX);
  wire ok_rate  = in_range(acc_wdata, `RATE_MIN, `RATE_MAX);
  wire ok_stop  = in_range(acc_wdata, `RATE_MIN, `RATE_MAX);
  wire ok_cur   = in_range(acc_wdata, `CURRENT_MIN, `CURRENT_MAX);
  wire ok_trig  = in_range(acc_wdata, `TRIG_MIN, `TRIG_ALL);
  wire ok_dest  = in_range(acc_wdata, `ZERO_WORD, `DEST_MAX);

  wire [6:0] item_ok = {ok_cur, ok_stop, ok_rate, ok_speed,
                        ok_pos, ok_type, ok_num};
  wire [6:0] item_wr = item_hit & item_ok & {7{wr}};
  wire trig_wr = wr & hit_trig & ok_trig;
  wire dest_wr = wr & hit_dest & ok_dest;
  wire ref_wr  = wr & (hit_main | hit_mirror);
  wire auto_wr = wr & hit_selfcl;

  wire bad_write = wr & ((|(item_hit & ~item_ok)) | (hit_trig & ~ok_trig)
                   | (hit_dest & ~ok_dest) | hit_ro);
  wire bad_read  = rd & hit_wo;
  wire unmapped  = acc_req & ~(hit_rw | hit_wo | hit_ro);
  wire err_d     = bad_write | bad_read | unmapped;

  // Parameter store
  always_comb begin
    params_d = params_q;
    if (item_wr[0]) params_d.data_num   = acc_wdata;
    if (item_wr[1]) params_d.op_type    = acc_wdata;
    if (item_wr[2]) params_d.position   = acc_wdata;
    if (item_wr[3]) params_d.speed      = acc_wdata;
    if (item_wr[4]) params_d.start_rate = acc_wdata;
    if (item_wr[5]) params_d.stop_decel = acc_wdata;
    if (item_wr[6]) params_d.current    = acc_wdata;
  end

  // Launch decision
  wire       trig_neg = trig_q[31];
  wire [2:0] trig_idx = trig_q[2:0] + `TRIG_IDX_BIAS;
  wire       trig_all = trig_q == `TRIG_ALL;
  wire [6:0] upd_now  = upd_q | item_wr;
  wire       fire_one = trig_neg & item_wr[trig_idx];
  wire       fire_all = trig_all & (&upd_now);
  wire       start_d  = fire_one | fire_all;

  assign upd_d = fire_all ? '0 : upd_now;

  // Input command word; a write wins over a pending automatic clear
  always_comb begin
    drv_in_d = drv_in_q & ~clr_mask;
    if (ref_wr | auto_wr) drv_in_d = acc_wdata;
  end

  input_auto_off #(
    .CYCLES   (AUTO_OFF_CYCLES)
  ) u_auto_off (
    .clk      (clk),
    .nrst     (nrst),
    .arm      (auto_wr),
    .arm_mask (acc_wdata),
    .cancel   (ref_wr),
    .clr_mask (clr_mask)
  );

  // Read selection
  wire [31:0] cmd_pos = drive_status.wrap_en ? drive_status.cmd_pos_wrap
                                             : drive_status.cmd_pos_abs;
  wire [31:0] rd_mux =
      ~rd        ? rdata_q :
      hit_num    ? params_q.data_num :
      hit_type   ? params_q.op_type :
      hit_pos    ? params_q.position :
      hit_speed  ? params_q.speed :
      hit_rate   ? params_q.start_rate :
      hit_stop   ? params_q.stop_decel :
      hit_cur    ? params_q.current :
      hit_trig   ? trig_q :
      hit_dest   ? dest_q :
      hit_outst  ? drive_status.out_status :
      hit_alarm  ? drive_status.alarm :
      hit_cerr   ? comm_err_q :
      hit_cpos   ? cmd_pos :
      hit_rpm    ? drive_status.speed_rpm :
      hit_hz     ? drive_status.speed_hz : `ZERO_WORD;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      params_q <= '0;
      trig_q   <= `TRIG_DISABLE;
      dest_q   <= `ZERO_WORD;
      upd_q    <= '0;
      drv_in_q <= `ZERO_WORD;
      start_q  <= 1'b0;
      to_buf_q <= 1'b0;
    end else begin
      params_q <= params_d;
      if (trig_wr) trig_q <= acc_wdata;
      if (dest_wr) dest_q <= acc_wdata;
      upd_q    <= upd_d;
      drv_in_q <= drv_in_d;
      start_q  <= start_d;
      to_buf_q <= dest_q[0] & move_busy;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comm_err_q <= `ZERO_WORD;
      ack_q      <= 1'b0;
      err_q      <= 1'b0;
      rdata_q    <= `ZERO_WORD;
    end else begin
      if (comm_err_valid) comm_err_q <= comm_err_code;
      ack_q   <= acc_req;
      err_q   <= err_d;
      rdata_q <= rd_mux;
    end
  end

  assign acc_ack        = ack_q;
  assign acc_err        = err_q;
  assign acc_rdata      = rdata_q;
  assign move_params    = params_q;
  assign move_start     = start_q;
  assign move_to_buffer = to_buf_q;
  assign drv_input      = drv_in_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  int unsigned hold_cnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt <= 0;
    end else if (ref_wr | auto_wr) begin
      hold_cnt <= 0;
    end else if (hold_cnt < AUTO_OFF_CYCLES + 2) begin
      hold_cnt <= hold_cnt + 1;
    end
  end

  // Bits of the last input command write and whether it was self-clearing, kept for the auto-off time check
  logic        auto_last_q;
  logic [31:0] auto_mask_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      auto_last_q <= 1'b0;
      auto_mask_q <= `ZERO_WORD;
    end else if (ref_wr | auto_wr) begin
      auto_last_q <= auto_wr;
      auto_mask_q <= acc_wdata;
    end
  end

  a_pos_full_range: assert property (
    wr && hit_pos |=> move_params.position == $past(acc_wdata))
    else $error("position write not stored");

  a_speed_limit: assert property (
    wr && hit_speed && !ok_speed |=> acc_err && $stable(move_params.speed))
    else $error("speed out of range not refused");

  a_rate_limit: assert property (
    wr && hit_rate && acc_wdata == `ZERO_WORD |=> acc_err)
    else $error("zero start rate accepted");

  a_stop_limit: assert property (
    $signed(move_params.stop_decel) <= $signed(`RATE_MAX))
    else $error("stop deceleration above limit");

  a_current_limit: assert property (
    $signed(move_params.current) <= $signed(`CURRENT_MAX) &&
    $signed(move_params.current) >= 0)
    else $error("current outside range");

  a_trig_disable: assert property (
    trig_q == `TRIG_DISABLE && !trig_wr |=> !move_start)
    else $error("move started while disabled");

  a_trig_single: assert property (
    trig_q == `TRIG_MIN && item_wr[0] |=> move_start)
    else $error("data number trigger missed");

  a_dest_buffer: assert property (
    move_busy && dest_q == `DEST_MAX |=> move_to_buffer)
    else $error("buffer destination not flagged");

  a_auto_off_time: assert property (
    auto_last_q && hold_cnt == AUTO_OFF_CYCLES + 1 |->
    (drv_input & auto_mask_q) == `ZERO_WORD)
    else $error("self-clearing bits not dropped");

  a_auto_off_hold: assert property (
    auto_wr |=> drv_input == $past(acc_wdata) ##1 drv_input == $past(acc_wdata, 2)
    || $past(ref_wr | auto_wr))
    else $error("self-clearing bits dropped early");

  a_mirror_main: assert property (
    wr && hit_mirror |=> drv_input == $past(acc_wdata))
    else $error("mirror word not applied");

  a_wo_read_err: assert property (
    rd && hit_main |=> acc_err && acc_rdata == `ZERO_WORD)
    else $error("write-only word readable");

  a_comm_err_hold: assert property (
    comm_err_valid ##1 (rd && hit_cerr && !comm_err_valid) |=>
    acc_rdata == $past(comm_err_code, 2))
    else $error("communication error not held");

  a_wrap_pos: assert property (
    rd && hit_cpos && drive_status.wrap_en |=>
    acc_rdata == $past(drive_status.cmd_pos_wrap))
    else $error("wrapped position not reported");

  a_num_limit: assert property (
    move_params.data_num <= `DATA_NUM_MAX)
    else $error("data number above limit");

  a_type_limit: assert property (
    wr && hit_type && !ok_type |=> acc_err)
    else $error("operation type out of range accepted");

  a_cur_refused: assert property (
    wr && hit_cur && !ok_cur |=> acc_err && $stable(move_params.current))
    else $error("current out of range not refused");

  a_dest_idle: assert property (
    !move_busy |=> !move_to_buffer)
    else $error("buffer destination flagged while idle");

  a_status_read: assert property (
    rd && hit_outst |=> acc_rdata == $past(drive_status.out_status))
    else $error("output status not reported");

  a_ro_write_err: assert property (
    wr && hit_ro |=> acc_err)
    else $error("read-only word accepted a write");

  a_alarm_read: assert property (
    rd && hit_alarm |=> acc_rdata == $past(drive_status.alarm))
    else $error("alarm code not reported");

  a_rpm_read: assert property (
    rd && hit_rpm |=> acc_rdata == $past(drive_status.speed_rpm))
    else $error("speed in rpm not reported");

  a_hz_read: assert property (
    rd && hit_hz |=> acc_rdata == $past(drive_status.speed_hz))
    else $error("speed in hertz not reported");

  c_single_trig: cover property (trig_neg && fire_one ##1 move_start);
  c_all_trig: cover property (trig_all && fire_all ##1 move_start);
  c_auto_off: cover property (|clr_mask);
  c_buffer: cover property (move_to_buffer);

endmodule : direct_move_regs
`default_nettype wire

// ---- core/input_auto_off.sv ----
// Timer that switches off self-clearing input bits after a fixed hold
`default_nettype none
`include "move_cfg.svh"
module input_auto_off
  import move_pkg::*;
#(
  parameter int CYCLES = `AUTO_OFF_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Arming and cancel
  input  wire logic        arm,
  input  wire logic [31:0] arm_mask,
  input  wire logic        cancel,
  // Bits to clear, one cycle
  output logic      [31:0] clr_mask
);

  off_state_t                state_q;
  off_state_t                state_d;
  logic [`AUTO_OFF_CW-1:0]   cnt_q;
  logic [`AUTO_OFF_CW-1:0]   cnt_d;
  logic [31:0]               mask_q;
  logic [31:0]               mask_d;
  logic [31:0]               clr_q;

  localparam logic [`AUTO_OFF_CW-1:0] LAST = `AUTO_OFF_CW'(CYCLES - 1);

  wire expire = (state_q == OFF_RUN) && (cnt_q == LAST) && !arm && !cancel;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    mask_d  = mask_q;
    case (state_q)
      OFF_IDLE: begin
        if (arm) begin
          state_d = OFF_RUN;
          cnt_d   = '0;
          mask_d  = arm_mask;
        end
      end
      OFF_RUN: begin
        if (cancel) begin
          state_d = OFF_IDLE;
          mask_d  = '0;
        end else if (arm) begin
          // A fresh write restarts the hold for all pending bits
          cnt_d  = '0;
          mask_d = mask_q | arm_mask;
        end else if (expire) begin
          state_d = OFF_IDLE;
          mask_d  = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = OFF_IDLE;
        mask_d  = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= OFF_IDLE;
      cnt_q   <= '0;
      mask_q  <= '0;
      clr_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      mask_q  <= mask_d;
      clr_q   <= expire ? mask_q : '0;
    end
  end

  assign clr_mask = clr_q;

endmodule : input_auto_off
`default_nettype wire

// ---- include/move_cfg.svh ----
// Identifiers, ranges and timing for the direct move command words
`ifndef MOVE_CFG_SVH
`define MOVE_CFG_SVH

`define ID_DATA_NUM     16'h002c
`define ID_OP_TYPE      16'h002d
`define ID_POSITION     16'h002e
`define ID_SPEED        16'h002f
`define ID_START_RATE   16'h0030
`define ID_STOP_DECEL   16'h0031
`define ID_CURRENT      16'h0032
`define ID_TRIGGER      16'h0033
`define ID_DEST         16'h0034
`define ID_IN_MIRROR    16'h003a
`define ID_IN_SELFCLR   16'h003c
`define ID_IN_MAIN      16'h003e
`define ID_OUT_STATUS   16'h003f
`define ID_ALARM        16'h0040
`define ID_COMM_ERR     16'h0056
`define ID_CMD_POS      16'h0063
`define ID_CMD_RPM      16'h0064
`define ID_CMD_HZ       16'h0065

`define POS_MIN         32'h80000000
`define POS_MAX         32'h7fffffff
`define SPEED_MIN       32'hffc2f700
`define SPEED_MAX       32'h003d0900
`define RATE_MIN        32'h00000001
`define RATE_MAX        32'h3b9aca00
`define CURRENT_MIN     32'h00000000
`define CURRENT_MAX     32'h000003e8
`define DATA_NUM_MAX    32'h000000ff
`define OP_TYPE_MAX     32'h00000016
`define TRIG_MIN        32'hfffffff9
`define TRIG_ALL        32'h00000001
`define TRIG_DISABLE    32'h00000000
`define TRIG_IDX_BIAS   3'h7
`define DEST_MAX        32'h00000001
`define ZERO_WORD       32'h00000000

`define NUM_ITEMS       7
`define CLK_PERIOD_NS   20
`define AUTO_OFF_NS     250000
`define AUTO_OFF_CYC    (`AUTO_OFF_NS / `CLK_PERIOD_NS)
`define AUTO_OFF_CW     14

`endif

// ---- include/move_pkg.sv ----
// Types shared by the direct move command word logic
`default_nettype none
package move_pkg;

  typedef struct packed {
    logic [31:0] data_num;
    logic [31:0] op_type;
    logic [31:0] position;
    logic [31:0] speed;
    logic [31:0] start_rate;
    logic [31:0] stop_decel;
    logic [31:0] current;
  } move_params_t;

  typedef struct packed {
    logic [31:0] out_status;
    logic [31:0] alarm;
    logic [31:0] cmd_pos_abs;
    logic [31:0] cmd_pos_wrap;
    logic        wrap_en;
    logic [31:0] speed_rpm;
    logic [31:0] speed_hz;
  } drive_status_t;

  typedef enum logic [1:0] {
    OFF_IDLE = 2'b01,
    OFF_RUN  = 2'b10
  } off_state_t;

endpackage : move_pkg
`default_nettype wire

// ---- test/motion_model.sv ----
// Behavioural motion core that answers the command word block
`default_nettype none
module motion_model
  import move_pkg::*;
#(
  parameter int BUSY_CYC = 20
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Stimulus from the bench
  input  wire drive_status_t status_in,
  input  wire logic          err_pulse,
  input  wire logic [31:0]   err_code_in,
  // Block side
  input  wire logic          move_start,
  output drive_status_t      drive_status,
  output logic               move_busy,
  output logic               comm_err_valid,
  output logic [31:0]        comm_err_code
);
  timeunit 1ns;
  timeprecision 1ns;

  int busy_cnt;

  assign move_busy = (busy_cnt != 0);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drive_status   <= '0;
      busy_cnt       <= 0;
      comm_err_valid <= 1'b0;
      comm_err_code  <= 32'h0;
    end else begin
      drive_status   <= status_in;
      busy_cnt       <= move_start ? BUSY_CYC : (move_busy ? busy_cnt - 1 : 0);
      comm_err_valid <= err_pulse;
      // Code is only meaningful with the pulse, so it shows garbage otherwise
      comm_err_code  <= err_pulse ? err_code_in : ~err_code_in;
    end
  end
endmodule : motion_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the direct move command words
`default_nettype none
`include "move_cfg.svh"
module tb_top
  import move_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int AUTO = 8;
  localparam logic [31:0] LO [9] = '{32'h0, 32'h0, `POS_MIN, `SPEED_MIN, `RATE_MIN,
                                     `RATE_MIN, `CURRENT_MIN, `TRIG_MIN, 32'h0};
  localparam logic [31:0] HI [9] = '{`DATA_NUM_MAX, `OP_TYPE_MAX, `POS_MAX, `SPEED_MAX,
                                     `RATE_MAX, `RATE_MAX, `CURRENT_MAX, `TRIG_ALL,
                                     `DEST_MAX};

  logic          clk;
  logic          nrst;
  logic          acc_req;
  logic          acc_wr;
  logic [15:0]   acc_id;
  logic [31:0]   acc_wdata;
  logic          acc_ack;
  logic          acc_err;
  logic [31:0]   acc_rdata;
  drive_status_t drive_status;
  drive_status_t st;
  logic          move_busy;
  logic          comm_err_valid;
  logic [31:0]   comm_err_code;
  logic          err_pulse;
  logic [31:0]   err_code_in;
  move_params_t  move_params;
  logic          move_start;
  logic          move_to_buffer;
  logic [31:0]   drv_input;
  logic          r_err;
  logic          r_start;
  logic [31:0]   r_data;
  logic [31:0]   v;
  logic [31:0]   cur;
  logic          e;
  logic          seen;
  int            seed;
  int            bad_count;
  int            compares;
  int            n;

  direct_move_regs #(.AUTO_OFF_CYCLES(AUTO)) uut (
    .clk(clk), .nrst(nrst), .acc_req(acc_req), .acc_wr(acc_wr), .acc_id(acc_id),
    .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_err(acc_err), .acc_rdata(acc_rdata),
    .drive_status(drive_status), .move_busy(move_busy), .comm_err_valid(comm_err_valid),
    .comm_err_code(comm_err_code), .move_params(move_params), .move_start(move_start),
    .move_to_buffer(move_to_buffer), .drv_input(drv_input)
  );

  motion_model partner (
    .clk(clk), .nrst(nrst), .status_in(st), .err_pulse(err_pulse),
    .err_code_in(err_code_in), .move_start(move_start), .drive_status(drive_status),
    .move_busy(move_busy), .comm_err_valid(comm_err_valid), .comm_err_code(comm_err_code)
  );

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask : check

  // One access; the answer is sampled in the acknowledge cycle
  task automatic acc(input logic wr, input logic [15:0] id, input logic [31:0] wd);
    @(posedge clk);
    #1;
    acc_req   = 1'b1;
    acc_wr    = wr;
    acc_id    = id;
    acc_wdata = wd;
    @(posedge clk);
    #1;
    acc_req   = 1'b0;
    acc_wdata = ~wd;
    check(acc_ack, 1'b1);
    r_err   = acc_err;
    r_data  = acc_rdata;
    r_start = move_start;
  endtask : acc

  task automatic wr_chk(input logic [15:0] id, input logic [31:0] wd, input logic exp_e);
    acc(1'b1, id, wd);
    check(r_err, exp_e);
  endtask : wr_chk

  task automatic rd_chk(input logic [15:0] id, input logic [31:0] exp_v);
    acc(1'b0, id, 32'h0);
    check(r_err, 1'b0);
    check(r_data, exp_v);
  endtask : rd_chk

  function automatic logic refused(input int i, input logic [31:0] val);
    return !($signed(val) >= $signed(LO[i]) && $signed(val) <= $signed(HI[i]));
  endfunction : refused

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #1000000;
    bad_count++;
    end_of_test();
  end

  initial begin
    seed = 32'hb216;
    bad_count = 0;
    compares = 0;
    nrst = 1'b0;
    acc_req = 1'b0;
    acc_wr = 1'b0;
    acc_id = 16'h0;
    acc_wdata = 32'h0;
    st = '0;
    err_pulse = 1'b0;
    err_code_in = 32'h0;
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    // Range limits, refused writes except on position, and random values per word
    for (int i = 0; i < 9; i++) begin
      wr_chk(16'h002c + 16'(i), LO[i], 1'b0);
      if (i != 2) begin
        wr_chk(16'h002c + 16'(i), LO[i] - 32'h1, 1'b1);
        wr_chk(16'h002c + 16'(i), HI[i] + 32'h1, 1'b1);
      end
      rd_chk(16'h002c + 16'(i), LO[i]);
      wr_chk(16'h002c + 16'(i), HI[i], 1'b0);
      rd_chk(16'h002c + 16'(i), HI[i]);
      cur = HI[i];
      for (int k = 0; k < 6; k++) begin
        v = $random(seed);
        if (k % 2 == 0) v = LO[i] + {22'h0, v[9:0]};
        e = refused(i, v);
        wr_chk(16'h002c + 16'(i), v, e);
        if (!e) cur = v;
        rd_chk(16'h002c + 16'(i), cur);
      end
    end
    // Each single-item trigger code
    for (int t = 0; t < 7; t++) begin
      wr_chk(`ID_TRIGGER, `TRIG_MIN + 32'(t), 1'b0);
      wr_chk(16'h002c + 16'((t + 1) % 7), HI[(t + 1) % 7], 1'b0);
      check(r_start, 1'b0);
      wr_chk(16'h002c + 16'(t), HI[t], 1'b0);
      check(r_start, 1'b1);
    end
    // All-updated trigger: sync on a launch, then seven fresh writes
    wr_chk(`ID_TRIGGER, `TRIG_ALL, 1'b0);
    seen = 1'b0;
    n = 0;
    while (!seen && n < 14) begin
      wr_chk(16'h002c + 16'(n % 7), HI[n % 7], 1'b0);
      seen = (r_start === 1'b1);
      n++;
    end
    check(seen, 1'b1);
    for (int j = 0; j < 7; j++) begin
      wr_chk(16'h002c + 16'((n + j) % 7), LO[(n + j) % 7], 1'b0);
      check(r_start, (j == 6));
    end
    wr_chk(`ID_TRIGGER, `TRIG_DISABLE, 1'b0);
    for (int j = 0; j < 7; j++) begin
      wr_chk(16'h002c + 16'(j), HI[j], 1'b0);
      check(r_start, 1'b0);
    end
    check(move_params.current, HI[6]);
    // Destination while a move runs and after it ends
    wr_chk(`ID_TRIGGER, 32'hfffffffb, 1'b0);
    wr_chk(`ID_DEST, 32'h1, 1'b0);
    wr_chk(`ID_POSITION, 32'h1234, 1'b0);
    check(move_params.position, 32'h1234);
    repeat (3) @(posedge clk);
    #1;
    check(move_to_buffer, 1'b1);
    wr_chk(`ID_DEST, 32'h0, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    check(move_to_buffer, 1'b0);
    repeat (30) @(posedge clk);
    wr_chk(`ID_DEST, 32'h1, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    check(move_to_buffer, 1'b0);
    // Input command words
    v = $random(seed);
    wr_chk(`ID_IN_MAIN, v, 1'b0);
    check(drv_input, v);
    wr_chk(`ID_IN_MIRROR, ~v, 1'b0);
    check(drv_input, ~v);
    wr_chk(`ID_IN_SELFCLR, v, 1'b0);
    check(drv_input, v);
    repeat (AUTO) @(posedge clk);
    #1;
    check(drv_input, v);
    @(posedge clk);
    #1;
    check(drv_input, 32'h0);
    wr_chk(`ID_IN_SELFCLR, v, 1'b0);
    wr_chk(`ID_IN_MAIN, 32'h5a5a_00ff, 1'b0);
    repeat (AUTO + 4) @(posedge clk);
    #1;
    check(drv_input, 32'h5a5a_00ff);
    foreach (HI[k]) begin
      if (k < 3) begin
        acc(1'b0, (k == 0) ? `ID_IN_MIRROR : (k == 1) ? `ID_IN_SELFCLR : `ID_IN_MAIN, 32'h0);
        check(r_err, 1'b1);
        check(r_data, 32'h0);
      end
    end
    // Status words from the motion core
    st = {$random(seed), $random(seed), $random(seed), $random(seed), 1'b0,
          $random(seed), $random(seed)};
    repeat (2) @(posedge clk);
    rd_chk(`ID_OUT_STATUS, st.out_status);
    rd_chk(`ID_ALARM, st.alarm);
    rd_chk(`ID_CMD_POS, st.cmd_pos_abs);
    rd_chk(`ID_CMD_RPM, st.speed_rpm);
    rd_chk(`ID_CMD_HZ, st.speed_hz);
    st.wrap_en = 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(`ID_CMD_POS, st.cmd_pos_wrap);
    // Read right behind the error pulse so the hold check sees it
    err_code_in = $random(seed);
    err_pulse = 1'b1;
    @(posedge clk);
    #1;
    err_pulse = 1'b0;
    rd_chk(`ID_COMM_ERR, err_code_in);
    // Writes to read-only words and unmapped identifiers
    wr_chk(`ID_OUT_STATUS, 32'h1, 1'b1);
    wr_chk(`ID_ALARM, 32'h1, 1'b1);
    wr_chk(`ID_COMM_ERR, 32'h1, 1'b1);
    wr_chk(`ID_CMD_POS, 32'h1, 1'b1);
    wr_chk(`ID_CMD_RPM, 32'h1, 1'b1);
    wr_chk(`ID_CMD_HZ, 32'h1, 1'b1);
    rd_chk(`ID_COMM_ERR, err_code_in);
    wr_chk(16'h0035, 32'h1, 1'b1);
    acc(1'b0, 16'h0000, 32'h0);
    check(r_err, 1'b1);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
